// [hw/pmdt_divider.sv]
// Clock tick divider producing oscillator, medium and subclock rate ticks.
`timescale 1ns/10ps
module pmdt_divider (
  input wire logic clk_in,                  // System clock.
  input wire logic rst_n_in,                // Synchronised reset, active low.
  input wire logic osc_run_in,              // Main oscillator running.
  input wire logic sub_edge_in,             // One subclock period elapsed.
  input wire logic [1:0] sub_rate_select_in, // Subactive rate choice.
  pmdt_tick_if.source tick                  // Tick outputs.
);
  import pmdt_pkg::*;
  logic [2:0] med_cnt_reg;
  logic [2:0] med_cnt_next;
  logic [2:0] sub_cnt_reg;
  logic [2:0] sub_cnt_next;
  always_comb begin
    med_cnt_next = osc_run_in ? 3'(med_cnt_reg + 3'h1) : 3'h0;
    sub_cnt_next = sub_edge_in ? 3'(sub_cnt_reg + 3'h1) : sub_cnt_reg;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      med_cnt_reg <= 3'h0;
      sub_cnt_reg <= 3'h0;
    end else begin
      med_cnt_reg <= med_cnt_next;
      sub_cnt_reg <= sub_cnt_next;
    end
  end
  assign tick.osc_tick = osc_run_in;
  assign tick.med_tick = osc_run_in && (med_cnt_reg == 3'h7);
  assign tick.sub_tick = sub_edge_in;
  always_comb begin
    case (sub_rate_select_in)
      PMDT_SUB_DIV1: tick.sub_rate_tick = sub_edge_in;
      PMDT_SUB_DIV4: tick.sub_rate_tick = sub_edge_in && (sub_cnt_reg[1:0] == 2'h3);
      default: tick.sub_rate_tick = sub_edge_in && (sub_cnt_reg == 3'h7);
    endcase
  end
endmodule : pmdt_divider

// [hw/pmdt_pkg.sv]
// Package holding the constants and types of the power mode direct transition controller.
package pmdt_pkg;
  typedef enum logic [1:0] {
    PMDT_HIGH,
    PMDT_MEDIUM,
    PMDT_SUB,
    PMDT_SLEEP
  } pmdt_mode_e;
  localparam logic [1:0] PMDT_SUB_DIV1 = 2'h0;
  localparam logic [1:0] PMDT_SUB_DIV4 = 2'h1;
  localparam logic [1:0] PMDT_SUB_DIV8 = 2'h2;
  localparam logic [2:0] PMDT_MED_DIV_LOG2 = 3'h3;
  localparam int PMDT_OLD_CYCLES = 3;
  localparam int PMDT_NEW_CYCLES = 14;
  localparam int PMDT_WAIT_DEFAULT = 8192;
  localparam logic [1:0] PMDT_MODE_RESET = 2'h0;
endpackage : pmdt_pkg

// [hw/pmdt_tick_if.sv]
// Interface carrying divided clock ticks from the divider to the controller.
`timescale 1ns/10ps
interface pmdt_tick_if;
  logic osc_tick;
  logic med_tick;
  logic sub_tick;
  logic sub_rate_tick;
  modport source (output osc_tick, output med_tick, output sub_tick, output sub_rate_tick);
  modport sink (input osc_tick, input med_tick, input sub_tick, input sub_rate_tick);
endinterface : pmdt_tick_if

// [hw/pmdt_top.sv]
// Power mode controller performing direct transitions between speed modes.
`timescale 1ns/10ps
module pmdt_top (
  input wire logic ref_clk_in,                   // System clock, 10 MHz.
  input wire logic resetn_in,                    // Asynchronous reset, active low.
  input wire logic sub_edge_in,                  // Subclock period pulse, from a pin domain.
  input wire logic sleep_exec_in,                // Sleep instruction executed, pulse.
  input wire logic [1:0] target_in,              // Requested mode: 0 high, 1 medium, 2 sub.
  input wire logic [1:0] sub_rate_select_in,     // Subactive rate choice.
  input wire logic direct_enable_in,             // Direct transition enable of wakeup_enable_two.
  input wire logic int_mask_in,                  // Interrupt mask flag of cpu_flags_word.
  input wire logic [15:0] osc_wait_in,           // Oscillator wait in states.
  output logic [1:0] mode_out,                   // Present mode.
  output logic osc_enable_out,                   // Main oscillator enable.
  output logic adc_pwm_enable_out,               // ADC and PWM run enable.
  output logic cpu_tick_out,                     // CPU clock tick.
  output logic busy_out,                         // Transition in progress.
  output logic stuck_out                         // Halted with no way back.
);
  import pmdt_pkg::*;
  typedef enum logic [1:0] {
    PMDT_IDLE,
    PMDT_OLD,
    PMDT_WAIT,
    PMDT_NEW
  } pmdt_state_e;
  logic rst_a_reg;
  logic rst_n;
  logic [2:0] sub_sync_reg;
  logic sub_pulse;
  pmdt_tick_if tick ();
  pmdt_state_e st_reg;
  pmdt_state_e st_next;
  pmdt_mode_e mode_reg;
  pmdt_mode_e mode_next;
  pmdt_mode_e tgt_reg;
  pmdt_mode_e tgt_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic stuck_reg;
  logic stuck_next;
  logic tick_reg;
  logic tick_next;
  logic old_tick;
  logic new_tick;
  logic osc_run;
  // Reset released through two stages so all logic leaves reset on one edge.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_a_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n <= rst_a_reg;
    end
  end
  // Subclock arrives from another domain; only the later two stages are compared.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sub_sync_reg <= 3'h0;
    end else begin
      sub_sync_reg <= {sub_sync_reg[1:0], sub_edge_in};
    end
  end
  assign sub_pulse = sub_sync_reg[1] && !sub_sync_reg[2];
  assign osc_run = (mode_reg != PMDT_SUB) || (st_reg == PMDT_WAIT) || (st_reg == PMDT_NEW);
  pmdt_divider u_div (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .osc_run_in(osc_run),
    .sub_edge_in(sub_pulse),
    .sub_rate_select_in(sub_rate_select_in),
    .tick(tick)
  );
  function automatic logic rate_tick(input pmdt_mode_e m, input logic o, input logic md,
                                     input logic s);
    case (m)
      PMDT_HIGH: rate_tick = o;
      PMDT_MEDIUM: rate_tick = md;
      PMDT_SUB: rate_tick = s;
      default: rate_tick = 1'b0;
    endcase
  endfunction : rate_tick
  assign old_tick = rate_tick(mode_reg, tick.osc_tick, tick.med_tick, tick.sub_rate_tick);
  assign new_tick = rate_tick(tgt_reg, tick.osc_tick, tick.med_tick, tick.sub_rate_tick);
  always_comb begin
    st_next = st_reg;
    mode_next = mode_reg;
    tgt_next = tgt_reg;
    cnt_next = cnt_reg;
    stuck_next = stuck_reg;
    tick_next = 1'b0;
    case (st_reg)
      PMDT_IDLE: begin
        tick_next = (mode_reg == PMDT_SLEEP) ? 1'b0 : old_tick;
        if (sleep_exec_in && (mode_reg != PMDT_SLEEP) && !stuck_reg) begin
          if (!direct_enable_in) begin
            mode_next = PMDT_SLEEP;
          end else if (int_mask_in) begin
            mode_next = PMDT_SLEEP;
            stuck_next = 1'b1;
          end else if (target_in != 2'(mode_reg) && target_in != 2'(PMDT_SLEEP)) begin
            tgt_next = pmdt_mode_e'(target_in);
            st_next = PMDT_OLD;
            cnt_next = 16'(PMDT_OLD_CYCLES);
          end
        end
      end
      PMDT_OLD: begin
        if (old_tick) begin
          cnt_next = 16'(cnt_reg - 16'h1);
          if (cnt_reg == 16'h1) begin
            if (mode_reg == PMDT_SUB) begin
              st_next = PMDT_WAIT;
              cnt_next = osc_wait_in;
            end else begin
              st_next = PMDT_NEW;
              cnt_next = 16'(PMDT_NEW_CYCLES);
            end
          end
        end
      end
      PMDT_WAIT: begin
        if (tick.osc_tick) begin
          cnt_next = 16'(cnt_reg - 16'h1);
          if (cnt_reg <= 16'h1) begin
            st_next = PMDT_NEW;
            cnt_next = 16'(PMDT_NEW_CYCLES);
          end
        end
      end
      PMDT_NEW: begin
        if (new_tick) begin
          cnt_next = 16'(cnt_reg - 16'h1);
          if (cnt_reg == 16'h1) begin
            st_next = PMDT_IDLE;
            mode_next = tgt_reg;
          end
        end
      end
      default: st_next = PMDT_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= PMDT_IDLE;
      mode_reg <= PMDT_HIGH;
      tgt_reg <= PMDT_HIGH;
      cnt_reg <= 16'h0;
      stuck_reg <= 1'b0;
      tick_reg <= 1'b0;
      mode_out <= PMDT_MODE_RESET;
      osc_enable_out <= 1'b1;
      adc_pwm_enable_out <= 1'b1;
      busy_out <= 1'b0;
    end else begin
      st_reg <= st_next;
      mode_reg <= mode_next;
      tgt_reg <= tgt_next;
      cnt_reg <= cnt_next;
      stuck_reg <= stuck_next;
      tick_reg <= tick_next;
      mode_out <= 2'(mode_next);
      osc_enable_out <= (mode_next != PMDT_SUB) || (st_next != PMDT_IDLE);
      adc_pwm_enable_out <= (mode_next == PMDT_HIGH) || (mode_next == PMDT_MEDIUM);
      busy_out <= (st_next != PMDT_IDLE);
    end
  end
  assign cpu_tick_out = tick_reg;
  assign stuck_out = stuck_reg;
endmodule : pmdt_top

// [verification/pmdt_monitor.sv]
// Checker of the mode, enable and transition timing outputs.
`timescale 1ns/10ps
module pmdt_monitor (
  input wire logic ref_clk_in, // Clock.
  input wire logic resetn_in, // Reset, active low.
  input wire logic sleep_exec_in, // Sleep pulse.
  input wire logic [1:0] target_in, // Requested mode.
  input wire logic direct_enable_in, // Direct enable.
  input wire logic int_mask_in, // Mask flag.
  input wire logic [1:0] mode_out, // Mode.
  input wire logic osc_enable_out, // Oscillator run.
  input wire logic adc_pwm_enable_out, // ADC run.
  input wire logic busy_out, // Busy.
  input wire logic stuck_out // Stuck.
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  logic go;
  logic fwd;
  assign go = sleep_exec_in && !busy_out && !stuck_out && mode_out != 2'h3;
  assign fwd = go && direct_enable_in && !int_mask_in;
  sub_osc_a: assert property (mode_out == 2'h2 && !busy_out |-> !osc_enable_out &&
    !adc_pwm_enable_out) else $error("Subactive idle with clocks on");
  fast_adc_a: assert property (!mode_out[1] && !busy_out |-> adc_pwm_enable_out &&
    osc_enable_out) else $error("Active mode with clocks off");
  no_direct_a: assert property (go && !direct_enable_in |=> mode_out == 2'h3 &&
    !busy_out) else $error("Disabled sleep not in sleep mode");
  mask_stuck_a: assert property (go && direct_enable_in && int_mask_in |=> stuck_out)
    else $error("Masked sleep not stuck");
  stuck_hold_a: assert property (stuck_out |=> stuck_out && mode_out == 2'h3)
    else $error("Stuck state left");
  hi_med_a: assert property (fwd && mode_out == 2'h0 && target_in == 2'h1 |=> busy_out
    ##[108:115] (!busy_out && mode_out == 2'h1)) else $error("High to medium time");
  med_hi_a: assert property (fwd && mode_out == 2'h1 && target_in == 2'h0 |=> busy_out
    ##[30:42] (!busy_out && mode_out == 2'h0)) else $error("Medium to high time");
  cover property (fwd && target_in == 2'h2);
  cover property (mode_out == 2'h2 && !busy_out);
  cover property (stuck_out);
endmodule : pmdt_monitor
bind pmdt_top pmdt_monitor mon_u (.ref_clk_in, .resetn_in, .sleep_exec_in, .target_in,
  .direct_enable_in, .int_mask_in, .mode_out, .osc_enable_out, .adc_pwm_enable_out,
  .busy_out, .stuck_out);

// [verification/pmdt_top_test.sv]
// Self-checking bench of the power mode controller.
`timescale 1ns/10ps
module pmdt_top_test;
  import pmdt_pkg::*;
  typedef struct {logic [1:0] t; logic [1:0] r; int lo; int hi; int per;} pmdt_row_s;
  logic clk = 1'b0, rst_n = 1'b0, sub = 1'b0, slp = 1'b0, den = 1'b1, msk = 1'b0;
  logic [1:0] tgt = 2'h0, rate = 2'h0, mode;
  logic osc, adc, tick, busy, stuck;
  int mismatches = 0, samples_checked = 0, n;
  // Bounds allow for the unknown phase of the old and new tick dividers.
  pmdt_row_s rows [8] = '{'{2'h1, 2'h0, 108, 115, 0}, '{2'h0, 2'h0, 31, 38, 0},
    '{2'h2, PMDT_SUB_DIV1, 134, 143, 10}, '{2'h1, 2'h0, 133, 142, 0},
    '{2'h2, PMDT_SUB_DIV4, 538, 584, 40}, '{2'h0, 2'h1, 99, 138, 0},
    '{2'h2, PMDT_SUB_DIV8, 1044, 1123, 80}, '{2'h0, 2'h2, 179, 258, 0}};
  always #50 clk = ~clk;
  always begin
    repeat (5) @(posedge clk);
    sub <= ~sub;
  end
  pmdt_top dut_u (.ref_clk_in(clk), .resetn_in(rst_n), .sub_edge_in(sub),
    .sleep_exec_in(slp), .target_in(tgt), .sub_rate_select_in(rate), .direct_enable_in(den),
    .int_mask_in(msk), .osc_wait_in(16'h0004), .mode_out(mode), .osc_enable_out(osc),
    .adc_pwm_enable_out(adc), .cpu_tick_out(tick), .busy_out(busy), .stuck_out(stuck));
  task automatic print_verdict();
    $display("Mismatches %0d of %0d checks", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset
  task automatic go(input logic [1:0] t, input logic [1:0] r);
    @(posedge clk);
    tgt <= t;
    rate <= r;
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
  endtask : go
  task automatic wait_tick();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tick !== 1'b1 && n < 200);
  endtask : wait_tick
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
  initial begin
    do_reset();
    for (int i = 0; i < 8; i++) begin
      go(rows[i].t, rows[i].r);
      for (n = 0; busy !== 1'b1 && n < 9; n++) @(negedge clk);
      for (n = 0; busy === 1'b1 && n < 2000; n++) @(negedge clk);
      chk_rng(n, rows[i].lo, rows[i].hi);
      @(negedge clk);
      chk({osc, adc, mode}, {{2{rows[i].t != 2'h2}}, rows[i].t});
      if (rows[i].per > 0) begin
        wait_tick();
        wait_tick();
        chk_rng(n, rows[i].per, rows[i].per);
      end
    end
    @(posedge clk) den <= 1'b0;
    go(2'h1, 2'h0);
    repeat (2) @(negedge clk);
    chk({stuck, busy, mode}, 4'h3);
    do_reset();
    @(posedge clk) den <= 1'b1;
    @(posedge clk) msk <= 1'b1;
    go(2'h1, 2'h0);
    repeat (2) @(negedge clk);
    chk({stuck, busy, mode}, 4'hb);
    @(posedge clk) msk <= 1'b0;
    go(2'h1, 2'h0);
    repeat (20) @(negedge clk);
    chk({stuck, busy, mode}, 4'hb);
    print_verdict();
  end
endmodule : pmdt_top_test
